// [rtl/kpd_scanner.sv]
`timescale 1ns/100ps

module kpd_scanner
    import kpd_pkg::*;
#(
    parameter int TIME_BASE_DIVIDE = TIME_BASE_CYCLES
) (
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    input  wire kpd_bus_req_type busReq,
    output logic [7:0]           busRdData,
    input  wire logic            timeBaseEnable,
    input  wire logic [5:0]      senseIn,
    output logic [4:0]           driveOut,
    output logic                 irqOut
);

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic timeTick;
    logic timeBaseLevel;

    kpd_time_base #(
        .DIVIDE (TIME_BASE_DIVIDE)
    ) u_time_base (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .runEnable (timeBaseEnable),
        .tick      (timeTick),
        .level     (timeBaseLevel)
    );

    // ------------------------------------------------------------
    // Sense pin synchroniser
    // ------------------------------------------------------------
    logic [5:0] senseMeta_q;
    logic [5:0] senseSync_q;
    logic       prevAllHigh_q;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            senseMeta_q <= SENSE_LINE_RST;
            senseSync_q <= SENSE_LINE_RST;
        end
        else
        begin
            senseMeta_q <= senseIn;
            senseSync_q <= senseMeta_q;
        end
    end

    logic allHigh;
    logic bypassEdge;

    assign allHigh    = &senseSync_q;
    // Runs on the system clock, so it works with the time base stopped
    assign bypassEdge = prevAllHigh_q && !allHigh;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prevAllHigh_q <= 1'b1;
        end
        else
        begin
            prevAllHigh_q <= allHigh;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    kpd_timing_type timing_q;
    logic           autoScanEnable_q;
    logic           irqEnable_q;
    logic           keyDetect_q;
    logic [4:0]     driveReg_q;
    logic [5:0]     senseReg_q;
    logic [2:0]     evtStatus_q;
    logic [2:0]     evtMask_q;
    logic           keyValidPulse_q;
    logic           keyInvalidPulse_q;
    logic           storeKey;
    logic [4:0]     foundDrive_q;
    logic [5:0]     foundSense_q;

    logic wrTiming;
    logic wrControl;
    logic rdControl;

    assign wrTiming  = busReq.wrStrobe && busReq.addr == TIMING_CONFIG_OFS;
    assign wrControl = busReq.wrStrobe && busReq.addr == CONTROL_FLAGS_OFS;
    assign rdControl = busReq.rdStrobe && busReq.addr == CONTROL_FLAGS_OFS;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            timing_q <= TIMING_CONFIG_RST;
        end
        else if (wrTiming)
        begin
            timing_q <= busReq.wrData;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            autoScanEnable_q <= 1'b0;
            irqEnable_q      <= 1'b0;
        end
        else if (wrControl)
        begin
            autoScanEnable_q <= busReq.wrData[CTL_AUTO_SCAN_BIT];
            irqEnable_q      <= busReq.wrData[CTL_IRQ_ENABLE_BIT];
        end
    end

    logic keySet;

    assign keySet = autoScanEnable_q ? keyValidPulse_q : bypassEdge;

    // Set is tested first so a detection landing on the clearing read survives
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            keyDetect_q <= 1'b0;
        end
        else if (keySet)
        begin
            keyDetect_q <= 1'b1;
        end
        else if (rdControl)
        begin
            keyDetect_q <= 1'b0;
        end
    end

    // Firmware owns the drive register only in bypass mode
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            driveReg_q <= DRIVE_LINE_RST;
            senseReg_q <= SENSE_LINE_RST;
        end
        else if (storeKey)
        begin
            driveReg_q <= foundDrive_q;
            senseReg_q <= foundSense_q;
        end
        else if (!autoScanEnable_q && busReq.wrStrobe && busReq.addr == DRIVE_LINE_OFS)
        begin
            driveReg_q <= busReq.wrData[4:0];
        end
    end

    // ------------------------------------------------------------
    // Event status and mask
    // ------------------------------------------------------------
    logic [2:0] evtSet;

    assign evtSet = {bypassEdge && !autoScanEnable_q, keyInvalidPulse_q, keyValidPulse_q};

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            evtStatus_q <= EVENT_RST;
        end
        else if (busReq.wrStrobe && busReq.addr == EVENT_STATUS_OFS)
        begin
            evtStatus_q <= (evtStatus_q & ~busReq.wrData[2:0]) | evtSet;
        end
        else
        begin
            evtStatus_q <= evtStatus_q | evtSet;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            evtMask_q <= EVENT_RST;
        end
        else if (busReq.wrStrobe && busReq.addr == EVENT_MASK_OFS)
        begin
            evtMask_q <= busReq.wrData[2:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            irqOut <= 1'b0;
        end
        else
        begin
            irqOut <= (keyDetect_q && irqEnable_q) || |(evtStatus_q & evtMask_q);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rdValue;

    always_comb
    begin
        rdValue = 8'h00;
        unique case (busReq.addr)
            DRIVE_LINE_OFS:    rdValue = {3'h0, driveReg_q};
            SENSE_LINE_OFS:    rdValue = {2'h0, autoScanEnable_q ? senseReg_q : senseSync_q};
            TIMING_CONFIG_OFS: rdValue = timing_q;
            CONTROL_FLAGS_OFS: rdValue = {4'h0, timeBaseLevel, autoScanEnable_q,
                                          keyDetect_q, irqEnable_q};
            EVENT_STATUS_OFS:  rdValue = {5'h00, evtStatus_q};
            EVENT_MASK_OFS:    rdValue = {5'h00, evtMask_q};
            default:           rdValue = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            busRdData <= 8'h00;
        end
        else if (busReq.rdStrobe)
        begin
            busRdData <= rdValue;
        end
        else
        begin
            busRdData <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Interval targets in time base ticks
    // ------------------------------------------------------------
    logic [8:0] debounceTicks;
    logic [8:0] intervalTicks;

    always_comb
    begin
        if (timing_q.debouncePeriodField == 6'h00)
        begin
            debounceTicks = DEBOUNCE_MAX_TICKS;
        end
        else
        begin
            debounceTicks = 9'(timing_q.debouncePeriodField * DEBOUNCE_STEP_TICKS);
        end
    end

    always_comb
    begin
        unique case (timing_q.perKeyIntervalField)
            2'h1:    intervalTicks = INTERVAL_1_TICKS;
            2'h2:    intervalTicks = INTERVAL_2_TICKS;
            2'h3:    intervalTicks = INTERVAL_3_TICKS;
            default: intervalTicks = INTERVAL_4_TICKS;
        endcase
    end

    // ------------------------------------------------------------
    // Hardware scan sequencer
    // ------------------------------------------------------------
    kpd_scan_state_type state_q;
    logic [8:0]         tickCnt_q;
    logic [2:0]         colIdx_q;
    logic [2:0]         rowIdx_q;
    logic [1:0]         hits_q;
    logic               debounceDone;
    logic               intervalDone;
    logic               lastKey;

    assign debounceDone = timeTick && (tickCnt_q + 9'h001 >= debounceTicks);
    assign intervalDone = timeTick && (tickCnt_q + 9'h001 >= intervalTicks);
    assign lastKey      = colIdx_q == LAST_DRIVE && rowIdx_q == LAST_SENSE;
    assign storeKey     = state_q == SC_REPORT && hits_q == 2'h1;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !autoScanEnable_q)
        begin
            state_q           <= SC_IDLE;
            tickCnt_q         <= 9'h000;
            colIdx_q          <= 3'h0;
            rowIdx_q          <= 3'h0;
            hits_q            <= 2'h0;
            foundDrive_q      <= DRIVE_LINE_RST;
            foundSense_q      <= SENSE_LINE_RST;
            keyValidPulse_q   <= 1'b0;
            keyInvalidPulse_q <= 1'b0;
        end
        else
        begin
            keyValidPulse_q   <= storeKey;
            keyInvalidPulse_q <= state_q == SC_REPORT && hits_q != 2'h1;
            if (timeTick)
            begin
                tickCnt_q <= tickCnt_q + 9'h001;
            end
            unique case (state_q)
                SC_IDLE:
                begin
                    tickCnt_q <= 9'h000;
                    if (!allHigh)
                    begin
                        state_q <= SC_PRESS_DEBOUNCE;
                    end
                end
                SC_PRESS_DEBOUNCE:
                begin
                    if (debounceDone)
                    begin
                        tickCnt_q <= 9'h000;
                        colIdx_q  <= 3'h0;
                        rowIdx_q  <= 3'h0;
                        hits_q    <= 2'h0;
                        state_q   <= allHigh ? SC_IDLE : SC_SCAN;
                    end
                end
                SC_SCAN:
                begin
                    if (intervalDone)
                    begin
                        tickCnt_q <= 9'h000;
                        if (!senseSync_q[rowIdx_q])
                        begin
                            if (hits_q != 2'h2)
                            begin
                                hits_q <= hits_q + 2'h1;
                            end
                            foundDrive_q <= ~(5'h01 << colIdx_q);
                            foundSense_q <= ~(6'h01 << rowIdx_q);
                        end
                        if (lastKey)
                        begin
                            state_q <= SC_REPORT;
                        end
                        else if (rowIdx_q == LAST_SENSE)
                        begin
                            rowIdx_q <= 3'h0;
                            colIdx_q <= colIdx_q + 3'h1;
                        end
                        else
                        begin
                            rowIdx_q <= rowIdx_q + 3'h1;
                        end
                    end
                end
                SC_REPORT:
                begin
                    state_q <= SC_WAIT_RELEASE;
                end
                SC_WAIT_RELEASE:
                begin
                    tickCnt_q <= 9'h000;
                    if (allHigh)
                    begin
                        state_q <= SC_RELEASE_DEBOUNCE;
                    end
                end
                SC_RELEASE_DEBOUNCE:
                begin
                    if (!allHigh)
                    begin
                        tickCnt_q <= 9'h000;
                    end
                    else if (debounceDone)
                    begin
                        state_q <= SC_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Drive lines
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            driveOut <= DRIVE_LINE_RST;
        end
        else if (!autoScanEnable_q)
        begin
            driveOut <= driveReg_q;
        end
        else if (state_q == SC_SCAN)
        begin
            driveOut <= ~(5'h01 << colIdx_q);
        end
        else
        begin
            driveOut <= 5'h00;
        end
    end

endmodule : kpd_scanner

// [rtl/kpd_pkg.sv]
package kpd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DRIVE_LINE_OFS      = 8'hd1;
    localparam logic [7:0] SENSE_LINE_OFS      = 8'hd2;
    localparam logic [7:0] TIMING_CONFIG_OFS   = 8'hd3;
    localparam logic [7:0] CONTROL_FLAGS_OFS   = 8'hd4;
    localparam logic [7:0] EVENT_STATUS_OFS    = 8'hd8;
    localparam logic [7:0] EVENT_MASK_OFS      = 8'hd9;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] DRIVE_LINE_RST      = 5'h1f;
    localparam logic [5:0] SENSE_LINE_RST      = 6'h3f;
    localparam logic [7:0] TIMING_CONFIG_RST   = 8'h00;
    localparam logic [2:0] EVENT_RST           = 3'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DEBOUNCE_MSB                = 7;
    localparam int DEBOUNCE_LSB                = 2;
    localparam int INTERVAL_MSB                = 1;
    localparam int INTERVAL_LSB                = 0;
    localparam int CTL_IRQ_ENABLE_BIT          = 0;
    localparam int CTL_KEY_DETECT_BIT          = 1;
    localparam int CTL_AUTO_SCAN_BIT           = 2;
    localparam int CTL_TIME_BASE_BIT           = 3;
    localparam int EVT_VALID_KEY_BIT           = 0;
    localparam int EVT_INVALID_KEY_BIT         = 1;
    localparam int EVT_EDGE_BIT                = 2;

    // ------------------------------------------------------------
    // Matrix size
    // ------------------------------------------------------------
    localparam int          DRIVE_LINES        = 5;
    localparam int          SENSE_LINES        = 6;
    localparam logic [2:0]  LAST_DRIVE         = 3'h4;
    localparam logic [2:0]  LAST_SENSE         = 3'h5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS               = 25;
    localparam int TIME_BASE_PERIOD_NS         = 1000000;
    localparam int TIME_BASE_CYCLES            = TIME_BASE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DEBOUNCE_STEP_MS            = 4;
    localparam int DEBOUNCE_MAX_MS             = 256;
    localparam int TIME_BASE_MS                = 1;
    localparam logic [8:0] DEBOUNCE_STEP_TICKS = 9'(DEBOUNCE_STEP_MS / TIME_BASE_MS);
    localparam logic [8:0] DEBOUNCE_MAX_TICKS  = 9'(DEBOUNCE_MAX_MS / TIME_BASE_MS);
    localparam logic [8:0] INTERVAL_1_TICKS    = 9'(1 / TIME_BASE_MS);
    localparam logic [8:0] INTERVAL_2_TICKS    = 9'(2 / TIME_BASE_MS);
    localparam logic [8:0] INTERVAL_3_TICKS    = 9'(3 / TIME_BASE_MS);
    localparam logic [8:0] INTERVAL_4_TICKS    = 9'(4 / TIME_BASE_MS);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wrStrobe;
        logic       rdStrobe;
    } kpd_bus_req_type;

    typedef struct packed {
        logic [5:0] debouncePeriodField;
        logic [1:0] perKeyIntervalField;
    } kpd_timing_type;

    typedef enum logic [2:0] {
        SC_IDLE,
        SC_PRESS_DEBOUNCE,
        SC_SCAN,
        SC_REPORT,
        SC_WAIT_RELEASE,
        SC_RELEASE_DEBOUNCE
    } kpd_scan_state_type;

endpackage : kpd_pkg

// [rtl/kpd_time_base.sv]
`timescale 1ns/100ps

module kpd_time_base #(
    parameter int DIVIDE = 40000
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic runEnable,
    output logic      tick,
    output logic      level
);

    logic [15:0] count_q;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !runEnable)
        begin
            count_q <= 16'h0000;
        end
        else if (count_q == 16'(DIVIDE - 1))
        begin
            count_q <= 16'h0000;
        end
        else
        begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Tick fires once per period; level is high for the first half
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !runEnable)
        begin
            tick  <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            tick  <= (count_q == 16'(DIVIDE - 1));
            level <= (count_q < 16'(DIVIDE / 2));
        end
    end

endmodule : kpd_time_base

// [sim/kpd_keypad_model.sv]
`timescale 1ns/100ps

module kpd_keypad_model (
    input  wire logic [29:0] keyDown,
    input  wire logic [4:0]  driveOut,
    output logic      [5:0]  senseIn
);
    // Rows have pull-ups, so a released row reads high, never a stale value
    always_comb
    begin
        senseIn = 6'h3f;
        for (int k = 0; k < 30; k++)
            if (keyDown[k] && !driveOut[k / 6])
                senseIn[k % 6] = 1'b0;
    end
endmodule : kpd_keypad_model

// [sim/kpd_scanner_props.sv]
`timescale 1ns/100ps

module kpd_scanner_props
    import kpd_pkg::*;
#(
    parameter int TIME_BASE_DIVIDE = 10
) (
    input wire logic            sys_clk,
    input wire logic            sys_rst,
    input wire kpd_bus_req_type busReq,
    input wire logic [7:0]      busRdData,
    input wire logic            timeBaseEnable,
    input wire logic [5:0]      senseIn,
    input wire logic [4:0]      driveOut,
    input wire logic            irqOut
);
    logic [7:0] ctlQ;
    logic [7:0] maskQ;
    logic [2:0] fallAge;
    logic       rdCtl;
    logic       wrCtl;
    logic       wrDrv;

    assign rdCtl = busReq.rdStrobe && busReq.addr == CONTROL_FLAGS_OFS;
    assign wrCtl = busReq.wrStrobe && busReq.addr == CONTROL_FLAGS_OFS;
    assign wrDrv = busReq.wrStrobe && busReq.addr == DRIVE_LINE_OFS;

    // Mode and mask shadowed from the bus, no internal state is visible
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ctlQ  <= 8'h00;
            maskQ <= 8'h00;
        end
        else if (wrCtl)
            ctlQ <= busReq.wrData;
        else if (busReq.wrStrobe && busReq.addr == EVENT_MASK_OFS)
            maskQ <= busReq.wrData;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || $fell(&senseIn))
            fallAge <= 3'h0;
        else if (fallAge != 3'h7)
            fallAge <= fallAge + 3'h1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // --------
    // Checks
    // --------
    a_timing_back: assert property (busReq.wrStrobe && busReq.addr == TIMING_CONFIG_OFS ##2
        busReq.rdStrobe && busReq.addr == TIMING_CONFIG_OFS |=> busRdData == $past(busReq.wrData, 3))
        else $error("timing register readback differs");
    a_ctl_upper: assert property (rdCtl |=> busRdData[7:4] == 4'h0)
        else $error("unused control bits read nonzero");
    a_clock_stop: assert property ((!timeBaseEnable)[*4] ##0 rdCtl |=> !busRdData[3])
        else $error("time base level high while stopped");
    a_flag_clear: assert property (rdCtl ##2 (rdCtl && !ctlQ[2] && fallAge == 3'h7) |=> !busRdData[1])
        else $error("key flag survived a read");
    a_bypass_irq: assert property (!ctlQ[2] && ctlQ[0] && $fell(&senseIn) |-> ##[1:8] (irqOut || rdCtl))
        else $error("bypass edge gave no interrupt");
    a_mask_quiet: assert property (!ctlQ[0] && !$past(ctlQ[0]) && maskQ == 8'h00
        && $past(maskQ) == 8'h00 |-> !irqOut)
        else $error("interrupt with all enables clear");
    a_auto_idle: assert property (wrCtl && busReq.wrData[2] && !ctlQ[2] && &senseIn
        |-> ##[1:3] driveOut == 5'h00)
        else $error("idle scan does not drive all lines low");
    a_bypass_drive: assert property (wrDrv && !ctlQ[2] |-> ##2 driveOut == $past(busReq.wrData[4:0], 2))
        else $error("drive lines do not follow register");

    c_auto_irq: cover property (irqOut && ctlQ[2]);
    c_flag_read: cover property (rdCtl ##1 busRdData[1]);
    c_bypass_fall: cover property ($fell(&senseIn) && !ctlQ[2]);
endmodule : kpd_scanner_props

bind kpd_scanner kpd_scanner_props #(.TIME_BASE_DIVIDE(TIME_BASE_DIVIDE)) u_props (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .busReq(busReq), .busRdData(busRdData), .timeBaseEnable(timeBaseEnable),
    .senseIn(senseIn), .driveOut(driveOut), .irqOut(irqOut));

// [sim/tb_top.sv]
`timescale 1ns/100ps

module tb_top
    import kpd_pkg::*;
;
    logic            sys_clk = 1'b0;
    logic            sys_rst;
    kpd_bus_req_type busReq;
    logic [7:0]      busRdData;
    logic            timeBaseEnable;
    logic [5:0]      senseIn;
    logic [4:0]      driveOut;
    logic            irqOut;
    logic [29:0]     keyDown;
    logic [7:0]      v;
    logic [1:0]      seen;
    logic [5:0]      dbTab [4] = '{6'h01, 6'h3f, 6'h00, 6'h03};
    logic [1:0]      ivTab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int              mismatches = 0;
    int              num_checks = 0;
    int              cycles = 0;
    int              n;
    int              c;
    int              r;
    int              t;

    always #12.5 sys_clk = ~sys_clk;

    // Short time base: one tick every 10 clocks keeps long debounces cheap
    kpd_scanner #(.TIME_BASE_DIVIDE(10)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq),
        .busRdData(busRdData), .timeBaseEnable(timeBaseEnable), .senseIn(senseIn), .driveOut(driveOut),
        .irqOut(irqOut));
    kpd_keypad_model u_keys (.keyDown(keyDown), .driveOut(driveOut), .senseIn(senseIn));

    function automatic int dbTicks(input logic [5:0] f);
        return (f == 6'h00) ? 256 : 4 * int'(f);
    endfunction : dbTicks

    function automatic int ivTicks(input logic [1:0] f);
        return (f == 2'h0) ? 4 : int'(f);
    endfunction : ivTicks

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkPin(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chkPin

    task automatic chkSpan(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : chkSpan

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) busReq <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk) busReq <= '0;
        #1 d = busRdData;
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a, v);
        chk8(v & m, e);
    endtask : rdChk

    task automatic waitIrq(input int limit);
        n = 0;
        while (irqOut !== 1'b1 && n < limit)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask : waitIrq

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        busReq = '0;
        timeBaseEnable = 1'b0;
        keyDown = '0;
        n = $urandom(32'h1c976dee);
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdChk(TIMING_CONFIG_OFS, 8'hff, 8'h00);
        rdChk(CONTROL_FLAGS_OFS, 8'hff, 8'h00);
        rdChk(DRIVE_LINE_OFS, 8'hff, 8'h1f);
        rdChk(8'h50, 8'hff, 8'h00);
        repeat (4)
        begin
            t = $urandom;
            wr(TIMING_CONFIG_OFS, 8'(t));
            rdChk(TIMING_CONFIG_OFS, 8'hff, 8'(t));
        end
        wr(CONTROL_FLAGS_OFS, 8'hf1);
        rdChk(CONTROL_FLAGS_OFS, 8'hff, 8'h01);
        // --------
        // Bypass scanning
        // --------
        wr(CONTROL_FLAGS_OFS, 8'h00);
        wr(DRIVE_LINE_OFS, 8'h1e);
        keyDown[2] <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chkPin(irqOut, 1'b0);
        rdChk(SENSE_LINE_OFS, 8'hff, 8'h3b);
        rdChk(CONTROL_FLAGS_OFS, 8'hff, 8'h02);
        rdChk(CONTROL_FLAGS_OFS, 8'hff, 8'h00);
        rdChk(EVENT_STATUS_OFS, 8'hff, 8'h04);
        wr(EVENT_MASK_OFS, 8'h04);
        repeat (3) @(posedge sys_clk);
        chkPin(irqOut, 1'b1);
        wr(EVENT_STATUS_OFS, 8'h04);
        repeat (3) @(posedge sys_clk);
        chkPin(irqOut, 1'b0);
        wr(EVENT_MASK_OFS, 8'h00);
        keyDown <= '0;
        wr(DRIVE_LINE_OFS, 8'h1f);
        wr(CONTROL_FLAGS_OFS, 8'h01);
        repeat (3)
        begin
            c = $urandom_range(4);
            r = $urandom_range(5);
            // Key goes down under released lines, so the drive write makes the fall
            keyDown[c * 6 + r] <= 1'b1;
            wr(DRIVE_LINE_OFS, 8'(5'h1f ^ (5'h01 << c)));
            // This read lands on the very edge that sets the flag
            repeat (2) @(posedge sys_clk);
            rdChk(CONTROL_FLAGS_OFS, 8'hff, 8'h01);
            waitIrq(20);
            chkPin(irqOut, 1'b1);
            rdChk(CONTROL_FLAGS_OFS, 8'hff, 8'h03);
            repeat (3) @(posedge sys_clk);
            chkPin(irqOut, 1'b0);
            keyDown <= '0;
            wr(DRIVE_LINE_OFS, 8'h1f);
            repeat (4) @(posedge sys_clk);
        end
        // --------
        // Hardware scanning
        // --------
        timeBaseEnable <= 1'b1;
        wr(DRIVE_LINE_OFS, 8'h1f);
        seen = 2'b00;
        repeat (12)
        begin
            rd(CONTROL_FLAGS_OFS, v);
            seen[v[3]] = 1'b1;
        end
        chkPin(&seen, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr(TIMING_CONFIG_OFS, {dbTab[i], ivTab[i]});
            wr(CONTROL_FLAGS_OFS, 8'h05);
            repeat (4) @(posedge sys_clk);
            chk8({3'h0, driveOut}, 8'h00);
            c = $urandom_range(4);
            r = $urandom_range(5);
            t = dbTicks(dbTab[i]) + 30 * ivTicks(ivTab[i]);
            keyDown[c * 6 + r] <= 1'b1;
            waitIrq((t + 4) * 10);
            chkSpan(n, (t - 2) * 10, (t + 2) * 10);
            rdChk(DRIVE_LINE_OFS, 8'hff, 8'(5'h1f ^ (5'h01 << c)));
            rdChk(SENSE_LINE_OFS, 8'hff, 8'(6'h3f ^ (6'h01 << r)));
            rdChk(CONTROL_FLAGS_OFS, 8'hf7, 8'h07);
            keyDown <= '0;
            repeat ((dbTicks(dbTab[i]) + 3) * 10) @(posedge sys_clk);
            chk8({3'h0, driveOut}, 8'h00);
        end
        wr(TIMING_CONFIG_OFS, 8'h05);
        keyDown <= 30'h0040_0001;
        repeat (380) @(posedge sys_clk);
        chkPin(irqOut, 1'b0);
        rdChk(CONTROL_FLAGS_OFS, 8'hf7, 8'h05);
        rdChk(EVENT_STATUS_OFS, 8'h02, 8'h02);
        // Bounce back down inside the release debounce: the timer must restart and hold
        keyDown <= '0;
        repeat (20) @(posedge sys_clk);
        keyDown <= 30'h0000_0001;
        repeat (450) @(posedge sys_clk);
        chkPin(irqOut, 1'b0);
        rdChk(CONTROL_FLAGS_OFS, 8'hf7, 8'h05);
        close_out();
    end
endmodule : tb_top
